/* File: rxohc_pkg.sv */
// package for the receive overhead capture register bank
package rxohc_pkg;
   localparam int                   RXOHC_ADDR_W      = 12;
   localparam int                   RXOHC_DATA_W      = 8;
   // register offsets; T1 link registers share the three lowest E1 offsets
   localparam logic [11:0]          RXOHC_OFS_ALIGN   = 12'h064;
   localparam logic [11:0]          RXOHC_OFS_NALIGN  = 12'h065;
   localparam logic [11:0]          RXOHC_OFS_SI_EVEN = 12'h066;
   localparam logic [11:0]          RXOHC_OFS_SI_ODD  = 12'h067;
   localparam logic [11:0]          RXOHC_OFS_RALARM  = 12'h068;
   localparam logic [11:0]          RXOHC_OFS_SA4     = 12'h069;
   localparam logic [11:0]          RXOHC_OFS_SA5     = 12'h06A;
   localparam logic [11:0]          RXOHC_OFS_SA6     = 12'h06B;
   localparam logic [11:0]          RXOHC_OFS_SA7     = 12'h06C;
   localparam logic [11:0]          RXOHC_OFS_SLC1    = 12'h064;
   localparam logic [11:0]          RXOHC_OFS_SLC2    = 12'h065;
   localparam logic [11:0]          RXOHC_OFS_SLC3    = 12'h066;
   localparam logic [7:0]           RXOHC_RST_VAL     = 8'h00;
   localparam logic [6:0]           RXOHC_FAS_PATTERN = 7'h1B;
   localparam logic                 RXOHC_MODE_T1     = 1'b0;
   localparam logic                 RXOHC_MODE_E1     = 1'b1;
   localparam logic [7:0]           RXOHC_UNMAPPED    = 8'h00;
   localparam int                   RXOHC_FRAME_W     = 4;
endpackage : rxohc_pkg

/* File: rxohc_capture.sv */
// receive overhead capture register bank: E1 timeslot-0 words and T1 SLC-96 link bits
//
// Operation
// R01 - In E1 mode the align-frame word shows the received international bit in bit 7 and the FAS 0011011 below it.
// R02 - In E1 mode the non-align-frame word holds Si, the fixed one, remote alarm and Sa4..Sa8 from bit 7 down.
// R03 - International bits of even frames 14..0 are gathered into one byte, frame 14 in bit 7 down to frame 0 in bit 0.
// R04 - International bits of odd frames 15..1 are gathered into one byte, frame 15 in bit 7 down to frame 1 in bit 0.
// R05 - Remote alarm bits of odd frames 15..1 are gathered into one byte, frame 15 in bit 7.
// R06 - Sa4, Sa5 and Sa6 each have a byte holding that bit from odd frames 15..1, frame 15 in bit 7.
// R07 - In T1 mode the three lowest addresses read the three SLC-96 link bytes instead of the E1 words.
// R08 - The receiver mode input selects the T1 (0) or E1 (1) meaning of the shared addresses.
// R09 - An Sa7 byte is laid out like the other spare-bit bytes.
// R10 - Bits update only on frames received in alignment, all registers reset to zero, host writes are ignored.
//
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module rxohc_capture
   import rxohc_pkg::*;
(
   // clock and reset
   input  wire logic                         sys_clk_i,
   input  wire logic                         resetn_i,
   // register port
   input  wire logic [RXOHC_ADDR_W-1:0]      reg_addr_i,
   input  wire logic [RXOHC_DATA_W-1:0]      reg_wdata_i,
   input  wire logic                         reg_wr_i,
   input  wire logic                         reg_rd_i,
   output logic      [RXOHC_DATA_W-1:0]      reg_rdata_o,
   // receiver mode and alignment state
   input  wire logic                         receiver_line_standard_select_i,
   input  wire logic                         frame_aligned_i,
   // E1 timeslot-0 byte, one strobe per received frame
   input  wire logic                         e1_ts0_valid_i,
   input  wire logic [RXOHC_FRAME_W-1:0]     e1_frame_num_i,
   input  wire logic [7:0]                   e1_ts0_byte_i,
   // T1 SLC-96 link bytes, one strobe per completed superframe
   input  wire logic                         slc_valid_i,
   input  wire logic [7:0]                   slc_first_i,
   input  wire logic [7:0]                   slc_second_i,
   input  wire logic [7:0]                   slc_third_i
);
   import rxohc_pkg::*;

   // capture registers, all read-only to the host
   logic [7:0] align_frame_word_r;
   logic [7:0] non_align_frame_word_r;
   logic [7:0] intl_bits_even_frames_r;
   logic [7:0] intl_bits_odd_frames_r;
   logic [7:0] remote_alarm_odd_frames_r;
   logic [7:0] spare_four_odd_frames_r;
   logic [7:0] spare_five_odd_frames_r;
   logic [7:0] spare_six_odd_frames_r;
   logic [7:0] spare_seven_odd_frames_r;
   logic [7:0] slc_link_bits_first_r;
   logic [7:0] slc_link_bits_second_r;
   logic [7:0] slc_link_bits_third_r;
   logic [7:0] reg_rdata_r;
   logic [7:0] rdata_nxt;

   // next values, one per capture register; the hold lives here, not in the flip-flops
   wire  [7:0] align_frame_word_nxt;
   wire  [7:0] non_align_frame_word_nxt;
   wire  [7:0] intl_bits_even_frames_nxt;
   wire  [7:0] intl_bits_odd_frames_nxt;
   wire  [7:0] remote_alarm_odd_frames_nxt;
   wire  [7:0] spare_four_odd_frames_nxt;
   wire  [7:0] spare_five_odd_frames_nxt;
   wire  [7:0] spare_six_odd_frames_nxt;
   wire  [7:0] spare_seven_odd_frames_nxt;
   wire  [7:0] slc_link_bits_first_nxt;
   wire  [7:0] slc_link_bits_second_nxt;
   wire  [7:0] slc_link_bits_third_nxt;

   // bit position within a gathered byte: frame 15/14 lands in bit 7
   function automatic logic [2:0] frame_slot(input logic [RXOHC_FRAME_W-1:0] frame);
      frame_slot = frame[3:1];
   endfunction : frame_slot

   // one-hot slot decode, used by every gathered byte
   function automatic logic [7:0] slot_onehot(input logic [RXOHC_FRAME_W-1:0] frame);
      slot_onehot = 8'h01 << frame_slot(frame);
   endfunction : slot_onehot

   // one register select, shared by every entry of the read map
   function automatic logic addr_hit(input logic [RXOHC_ADDR_W-1:0] addr, input logic [11:0] offset);
      addr_hit = (addr == offset);
   endfunction : addr_hit

   // capture only while aligned; a frame taken out of alignment would poison the bytes
   wire        is_e1        = (receiver_line_standard_select_i == RXOHC_MODE_E1);      // R08
   wire        e1_take      = e1_ts0_valid_i & frame_aligned_i & is_e1;                 // R10
   wire        slc_take     = slc_valid_i & frame_aligned_i & ~is_e1;                   // R10
   wire        fas_frame    = ~e1_frame_num_i[0];
   wire        even_take    = e1_take & fas_frame;
   wire        odd_take     = e1_take & ~fas_frame;
   wire [7:0]  slot_sel     = slot_onehot(e1_frame_num_i);

   // fields of the timeslot-0 byte, first received bit in bit 7
   wire        si_bit       = e1_ts0_byte_i[7];
   wire        ra_bit       = e1_ts0_byte_i[5];
   wire        sa4_bit      = e1_ts0_byte_i[4];
   wire        sa5_bit      = e1_ts0_byte_i[3];
   wire        sa6_bit      = e1_ts0_byte_i[2];
   wire        sa7_bit      = e1_ts0_byte_i[1];

   // the word registers keep the whole received byte; the FAS field shows the pattern as received
   assign align_frame_word_nxt     = even_take ? {si_bit, e1_ts0_byte_i[6:0]} : align_frame_word_r;     // R01
   assign non_align_frame_word_nxt = odd_take ? e1_ts0_byte_i : non_align_frame_word_r;                // R02

   // gathered bytes: each bit is rewritten only in its own frame of the multiframe
   // frame n lands in slot n/2, so both halves of the multiframe share one slot decode
   genvar g;
   generate
      for (g = 0; g < 8; g++)
      begin : g_si_even
         assign intl_bits_even_frames_nxt[g] = (even_take && slot_sel[g]) ? si_bit : intl_bits_even_frames_r[g]; // R03
      end

      for (g = 0; g < 8; g++)
      begin : g_si_odd
         assign intl_bits_odd_frames_nxt[g] = (odd_take && slot_sel[g]) ? si_bit : intl_bits_odd_frames_r[g];    // R04
      end

      for (g = 0; g < 8; g++)
      begin : g_alarm
         assign remote_alarm_odd_frames_nxt[g] = (odd_take && slot_sel[g]) ? ra_bit : remote_alarm_odd_frames_r[g]; // R05
      end

      for (g = 0; g < 8; g++)
      begin : g_sa4
         assign spare_four_odd_frames_nxt[g] = (odd_take && slot_sel[g]) ? sa4_bit : spare_four_odd_frames_r[g];  // R06
      end

      for (g = 0; g < 8; g++)
      begin : g_sa5
         assign spare_five_odd_frames_nxt[g] = (odd_take && slot_sel[g]) ? sa5_bit : spare_five_odd_frames_r[g];  // R06
      end

      for (g = 0; g < 8; g++)
      begin : g_sa6
         assign spare_six_odd_frames_nxt[g] = (odd_take && slot_sel[g]) ? sa6_bit : spare_six_odd_frames_r[g];    // R06
      end

      for (g = 0; g < 8; g++)
      begin : g_sa7
         assign spare_seven_odd_frames_nxt[g] = (odd_take && slot_sel[g]) ? sa7_bit : spare_seven_odd_frames_r[g]; // R09
      end
   endgenerate

   // SLC-96 link bytes arrive already packed by the T1 framer
   assign slc_link_bits_first_nxt  = slc_take ? slc_first_i  : slc_link_bits_first_r;                 // R07
   assign slc_link_bits_second_nxt = slc_take ? slc_second_i : slc_link_bits_second_r;                // R07
   assign slc_link_bits_third_nxt  = slc_take ? slc_third_i  : slc_link_bits_third_r;                 // R07

   // every register loads its next value each cycle; reset clears all of them to zero
   // E1 word registers
   always_ff @(posedge sys_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         align_frame_word_r <= RXOHC_RST_VAL;                                                       // R10
      else
         align_frame_word_r <= align_frame_word_nxt;
   end

   always_ff @(posedge sys_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         non_align_frame_word_r <= RXOHC_RST_VAL;                                                   // R10
      else
         non_align_frame_word_r <= non_align_frame_word_nxt;
   end

   // gathered bytes
   always_ff @(posedge sys_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         intl_bits_even_frames_r <= RXOHC_RST_VAL;                                                  // R10
      else
         intl_bits_even_frames_r <= intl_bits_even_frames_nxt;
   end

   always_ff @(posedge sys_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         intl_bits_odd_frames_r <= RXOHC_RST_VAL;                                                   // R10
      else
         intl_bits_odd_frames_r <= intl_bits_odd_frames_nxt;
   end

   always_ff @(posedge sys_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         remote_alarm_odd_frames_r <= RXOHC_RST_VAL;                                                // R10
      else
         remote_alarm_odd_frames_r <= remote_alarm_odd_frames_nxt;
   end

   always_ff @(posedge sys_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         spare_four_odd_frames_r <= RXOHC_RST_VAL;                                                  // R10
      else
         spare_four_odd_frames_r <= spare_four_odd_frames_nxt;
   end

   always_ff @(posedge sys_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         spare_five_odd_frames_r <= RXOHC_RST_VAL;                                                  // R10
      else
         spare_five_odd_frames_r <= spare_five_odd_frames_nxt;
   end

   always_ff @(posedge sys_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         spare_six_odd_frames_r <= RXOHC_RST_VAL;                                                   // R10
      else
         spare_six_odd_frames_r <= spare_six_odd_frames_nxt;
   end

   always_ff @(posedge sys_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         spare_seven_odd_frames_r <= RXOHC_RST_VAL;                                                 // R10
      else
         spare_seven_odd_frames_r <= spare_seven_odd_frames_nxt;
   end

   // T1 link bytes
   always_ff @(posedge sys_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         slc_link_bits_first_r <= RXOHC_RST_VAL;                                                    // R10
      else
         slc_link_bits_first_r <= slc_link_bits_first_nxt;
   end

   always_ff @(posedge sys_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         slc_link_bits_second_r <= RXOHC_RST_VAL;                                                   // R10
      else
         slc_link_bits_second_r <= slc_link_bits_second_nxt;
   end

   always_ff @(posedge sys_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         slc_link_bits_third_r <= RXOHC_RST_VAL;                                                    // R10
      else
         slc_link_bits_third_r <= slc_link_bits_third_nxt;
   end

   // read map; writes are accepted and dropped since every register is read-only
   // the three lowest addresses change meaning with the receiver mode
   wire        hit_align    = addr_hit(reg_addr_i, RXOHC_OFS_ALIGN);
   wire        hit_nalign   = addr_hit(reg_addr_i, RXOHC_OFS_NALIGN);
   wire        hit_si_even  = addr_hit(reg_addr_i, RXOHC_OFS_SI_EVEN);

   wire        hit_si_odd   = addr_hit(reg_addr_i, RXOHC_OFS_SI_ODD);
   wire        hit_ralarm   = addr_hit(reg_addr_i, RXOHC_OFS_RALARM);
   wire        hit_sa4      = addr_hit(reg_addr_i, RXOHC_OFS_SA4);
   wire        hit_sa5      = addr_hit(reg_addr_i, RXOHC_OFS_SA5);
   wire        hit_sa6      = addr_hit(reg_addr_i, RXOHC_OFS_SA6);
   wire        hit_sa7      = addr_hit(reg_addr_i, RXOHC_OFS_SA7);

   // shared addresses
   wire [7:0]  word_first   = is_e1 ? align_frame_word_r      : slc_link_bits_first_r;                 // R07
   wire [7:0]  word_second  = is_e1 ? non_align_frame_word_r  : slc_link_bits_second_r;                // R07
   wire [7:0]  word_third   = is_e1 ? intl_bits_even_frames_r : slc_link_bits_third_r;                 // R07

   // unmapped addresses fall through to zero since no select is set
   assign rdata_nxt = ({8{hit_align}}   & word_first)
                    | ({8{hit_nalign}}  & word_second)
                    | ({8{hit_si_even}} & word_third)
                    | ({8{hit_si_odd}}  & intl_bits_odd_frames_r)
                    | ({8{hit_ralarm}}  & remote_alarm_odd_frames_r)
                    | ({8{hit_sa4}}     & spare_four_odd_frames_r)
                    | ({8{hit_sa5}}     & spare_five_odd_frames_r)
                    | ({8{hit_sa6}}     & spare_six_odd_frames_r)
                    | ({8{hit_sa7}}     & spare_seven_odd_frames_r)
                    | RXOHC_UNMAPPED;

   // read data stands for exactly one cycle after the strobe
   // returning to zero keeps a late sample from mistaking stale data for an answer
   always_ff @(posedge sys_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         reg_rdata_r <= RXOHC_RST_VAL;
      else if (reg_rd_i)
         reg_rdata_r <= rdata_nxt;
      else
         reg_rdata_r <= RXOHC_RST_VAL;
   end

   // write port is ignored; these wires only keep the unused inputs visible
   wire unused_wr = reg_wr_i ^ (^reg_wdata_i);                                            // R10

   assign reg_rdata_o = reg_rdata_r;

endmodule : rxohc_capture
`default_nettype wire

/* File: rxohc_capture_properties.sv */
// port assertions for the receive overhead capture bank
`timescale 1ns/1ps
`default_nettype none
module rxohc_capture_properties
   import rxohc_pkg::*;
(
   input wire logic sys_clk_i, resetn_i, reg_wr_i, reg_rd_i, frame_aligned_i, e1_ts0_valid_i, slc_valid_i,
   input wire logic receiver_line_standard_select_i,
   input wire logic [RXOHC_ADDR_W-1:0] reg_addr_i,
   input wire logic [RXOHC_FRAME_W-1:0] e1_frame_num_i,
   input wire logic [7:0] reg_wdata_i, reg_rdata_o, e1_ts0_byte_i, slc_first_i, slc_second_i, slc_third_i
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!resetn_i);
   wire logic e1 = receiver_line_standard_select_i;
   // a fresh capture in the read cycle lands after the read sample and cannot change the answer
   sequence s_cap(n, a);
      e1_ts0_valid_i && frame_aligned_i && e1 && e1_frame_num_i == n
      ##1 reg_rd_i && reg_addr_i == a && e1 && !e1_ts0_valid_i;
   endsequence
   property p_bit(n, a, b);
      s_cap(n, a) |=> reg_rdata_o[7] == $past(e1_ts0_byte_i[b], 2);
   endproperty
   a_read_idle: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00) else $error("idle");
   a_align_word: assert property (s_cap(14, RXOHC_OFS_ALIGN) |=> reg_rdata_o == $past(e1_ts0_byte_i, 2))
      else $error("align");
   a_nalign_word: assert property (s_cap(15, RXOHC_OFS_NALIGN) |=> reg_rdata_o == $past(e1_ts0_byte_i, 2))
      else $error("non-align");
   a_even_si_bit: assert property (p_bit(14, RXOHC_OFS_SI_EVEN, 7)) else $error("si even");
   a_odd_si_bit: assert property (p_bit(15, RXOHC_OFS_SI_ODD, 7)) else $error("si odd");
   a_alarm_bit: assert property (p_bit(15, RXOHC_OFS_RALARM, 5)) else $error("alarm");
   a_spare_bit: assert property (p_bit(15, RXOHC_OFS_SA4, 4)) else $error("spare");
   a_slc_first: assert property (slc_valid_i && frame_aligned_i && !e1 ##1 reg_rd_i && !e1
      && reg_addr_i == RXOHC_OFS_SLC1 && !slc_valid_i |=> reg_rdata_o == $past(slc_first_i, 2)) else $error("slc");
endmodule : rxohc_capture_properties
bind rxohc_capture rxohc_capture_properties u_props (.*);
`default_nettype wire

/* File: rxohc_line_model.sv */
// remote line side: E1 timeslot-0 bytes and SLC-96 link bytes
`timescale 1ns/1ps
`default_nettype none
module rxohc_line_model (
   input wire logic sys_clk_i,
   output logic e1_valid_o, slc_valid_o,
   output logic [3:0] e1_frame_o,
   output logic [7:0] e1_byte_o, slc_a_o, slc_b_o, slc_c_o
);
   initial {e1_valid_o, slc_valid_o, e1_frame_o, e1_byte_o, slc_a_o, slc_b_o, slc_c_o} = '0;
   // the line keeps no byte after its strobe, so the inverse shows
   // with more set the strobe stays up for a back-to-back frame, so it is never written twice in one step
   task automatic send_e1(input logic [3:0] n, input logic [7:0] d, input bit more = 1'b0);
      {e1_valid_o, e1_frame_o, e1_byte_o} <= {1'b1, n, d};
      @(posedge sys_clk_i);
      if (!more) {e1_valid_o, e1_byte_o} <= {1'b0, ~d};
   endtask : send_e1
   task automatic send_slc(input logic [7:0] a, b, c);
      {slc_valid_o, slc_a_o, slc_b_o, slc_c_o} <= {1'b1, a, b, c};
      @(posedge sys_clk_i);
      {slc_valid_o, slc_a_o, slc_b_o, slc_c_o} <= {1'b0, ~a, ~b, ~c};
   endtask : send_slc
endmodule : rxohc_line_model
`default_nettype wire

/* File: rxohc_capture_tb_top.sv */
// self-checking bench for the receive overhead capture bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(e, s) checks++; if ((s) !== (e)) begin $display("BAD reg_rdata_o exp %h got %h", e, s); bad_count++; end
module rxohc_capture_tb_top;
   import rxohc_pkg::*;
   logic sys_clk_i, resetn_i, reg_wr_i, reg_rd_i, frame_aligned_i, e1_ts0_valid_i, slc_valid_i;
   logic receiver_line_standard_select_i;
   logic [11:0] reg_addr_i;
   logic [3:0] e1_frame_num_i;
   logic [7:0] reg_wdata_i, reg_rdata_o, e1_ts0_byte_i, slc_first_i, slc_second_i, slc_third_i, b, e [7];
   int bad_count, checks;
   rxohc_capture uut (.*);
   rxohc_line_model lm (.sys_clk_i, .e1_valid_o(e1_ts0_valid_i), .e1_frame_o(e1_frame_num_i), .e1_byte_o(e1_ts0_byte_i),
      .slc_valid_o(slc_valid_i), .slc_a_o(slc_first_i), .slc_b_o(slc_second_i), .slc_c_o(slc_third_i));
   initial begin sys_clk_i = 1'b0; forever #2 sys_clk_i = ~sys_clk_i; end
   // the whole run is about 115 cycles
   initial begin #8000; bad_count++; complete_run; end
   task automatic rd(input logic [11:0] a, input logic [7:0] x);
      {reg_addr_i, reg_rd_i} <= {a, 1'b1};
      @(posedge sys_clk_i);
      reg_rd_i <= 1'b0;
      #1 `CHK(x, reg_rdata_o)
   endtask : rd
   task automatic reset_check;
      resetn_i <= 1'b0;
      repeat (20) @(posedge sys_clk_i);
      #1 resetn_i <= 1'b1;
      @(posedge sys_clk_i);
      for (int a = 'h64; a < 'h71; a++) rd(12'(a), RXOHC_RST_VAL);
      $display("reset test done");
   endtask : reset_check
   task automatic complete_run;
      $display("checks %0d bad_count %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : complete_run
   initial
   begin
      {reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i, resetn_i} = '0;
      {frame_aligned_i, receiver_line_standard_select_i} = {1'b1, RXOHC_MODE_E1};
      reset_check;
      for (int n = 0; n < 16; n++)
      begin
         b = 8'(n) * 8'h2D;
         if (!n[0]) e[0][n/2] = b[7];
         else for (int k = 1; k < 7; k++) e[k][n/2] = b[k == 1 ? 7 : 7 - k];
         lm.send_e1(4'(n), b, n < 15);
      end
      // frames 14 (0x76) and 15 (0xA3) again, each read right after its capture
      for (int i = 0; i < 9; i++)
      begin
         b = (i == 0 || i == 2) ? 8'h76 : 8'hA3;
         lm.send_e1(b[0] ? 4'hF : 4'hE, b);
         rd(12'h064 + 12'(i), i < 2 ? b : e[i-2]);
      end
      $display("e1 capture test done");
      frame_aligned_i <= 1'b0;
      lm.send_e1(4'hF, 8'h5C);
      {reg_addr_i, reg_wdata_i, reg_wr_i} <= {RXOHC_OFS_SI_ODD, 8'hFF, 1'b1};
      @(posedge sys_clk_i);
      reg_wr_i <= 1'b0;
      rd(RXOHC_OFS_SI_ODD, e[1]);
      rd(RXOHC_OFS_NALIGN, 8'hA3);
      {frame_aligned_i, receiver_line_standard_select_i} <= {1'b1, RXOHC_MODE_T1};
      lm.send_e1(4'hF, 8'h5C);
      for (int i = 0; i < 3; i++)
      begin
         lm.send_slc(8'hA5, 8'h96, 8'h69);
         rd(12'h064 + 12'(i), i == 0 ? 8'hA5 : i == 1 ? 8'h96 : 8'h69);
      end
      rd(RXOHC_OFS_SI_ODD, e[1]);
      receiver_line_standard_select_i <= RXOHC_MODE_E1;
      rd(RXOHC_OFS_ALIGN, 8'h76);
      $display("mode test done");
      reset_check;
      complete_run;
   end
endmodule : rxohc_capture_tb_top
`default_nettype wire
